/* rtl/sbc_pkg.sv */
// Purpose: Shared constants and types for the serial command decoder.
// Assumes: 16-bit frames, most significant bit first.
// Notes: Frame field positions and register reset values live here.
package sbc_pkg;
   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int CMD_HI = 15;
   localparam int CMD_LO = 14;
   localparam int ADDR_HI = 13;
   localparam int ADDR_LO = 9;
   localparam int PARITY_BIT = 8;
   localparam int SUB_BIT = 7;
   localparam int PARITY_EN_BIT = 6;
   localparam logic [4:0] ADDR_ANALOG_MONITOR_SELECT = 5'h00;
   localparam logic [7:0] ANALOG_MONITOR_SELECT_RESET = 8'h00;
   localparam logic [7:0] ANALOG_MONITOR_SELECT_MASK = 8'hF8;
   localparam logic [4:0] COUNT_RESET = 5'h00;
   localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 5;
   localparam int RES_EN_BIT = 4;
   localparam int ATTEN_BIT = 3;

   typedef enum logic [1:0] {
      CMD_READ_CTRL = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_RESERVED = 2'h2,
      CMD_READ_FLAGS = 2'h3
   } sbc_cmd_t;

   // A decoded frame handed from the link domain to the core domain.
   typedef struct packed {
      sbc_cmd_t cmd;
      logic [4:0] addr;
      logic parity;
      logic sub;
      logic [6:0] low;
   } sbc_frame_t;

   // Analog monitor controls driven by the register.
   typedef struct packed {
      logic [2:0] sel;
      logic res_en;
      logic atten;
   } sbc_mon_t;
endpackage : sbc_pkg

/* rtl/sbc_sync.sv */
// Purpose: Two flip-flop synchroniser for single-bit levels.
// Assumes: Input is a level from another clock domain.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
module sbc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule : sbc_sync

/* rtl/sbc_link.sv */
// Purpose: Serial link shifter on the host clock.
// Assumes: Host clock runs only while chip select is active.
// Notes: Frame end is flagged by a toggle; reply is loaded at frame start.
`timescale 1ns/100ps
module sbc_link (
   input wire logic link_clock_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic mosi_i,
   input wire logic [sbc_pkg::FRAME_BITS-1:0] reply_i,
   output logic miso_o,
   output logic [sbc_pkg::FRAME_BITS-1:0] frame_o,
   output logic done_tgl_o
);
   import sbc_pkg::*;

   logic [FRAME_BITS-1:0] rx_r;
   logic [FRAME_BITS-1:0] tx_r;
   logic [4:0] cnt_r;
   logic tgl_r;
   logic [FRAME_BITS-1:0] rx_nxt;

   assign rx_nxt = {rx_r[FRAME_BITS-2:0], mosi_i};

   // ----------------------------------------------------------------
   // Shift register
   // ----------------------------------------------------------------
   // Chip select high clears the bit count without needing a clock edge.
   always_ff @(posedge link_clock_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         cnt_r <= COUNT_RESET;
      end else begin
         cnt_r <= (cnt_r == 5'(FRAME_BITS - 1)) ? COUNT_RESET : cnt_r + 5'h01; // [R16]
      end
   end

   always_ff @(posedge link_clock_i) begin
      rx_r <= rx_nxt; // [R16]
      if (!cs_b_i && cnt_r == 5'(FRAME_BITS - 1)) begin
         frame_o <= rx_nxt;
      end
   end

   // The core reset clears the frame toggle; the link clock is idle while reset is low.
   always_ff @(posedge link_clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgl_r <= 1'b0;
      end else if (!cs_b_i && cnt_r == 5'(FRAME_BITS - 1)) begin
         tgl_r <= ~tgl_r;
      end
   end

   // Bit 15 comes straight from the reply while the count is zero; the first falling edge loads the rest.
   always_ff @(negedge link_clock_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         tx_r <= SHIFT_RESET;
      end else if (cnt_r == 5'h01) begin
         tx_r <= {reply_i[FRAME_BITS-2:0], 1'b0};
      end else begin
         tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      end
   end

   assign miso_o = (cnt_r == COUNT_RESET && !cs_b_i) ? reply_i[FRAME_BITS-1] : tx_r[FRAME_BITS-1]; // [R16]
   assign done_tgl_o = tgl_r;
endmodule : sbc_link

/* rtl/sbc_cmd.sv */
// Purpose: Serial command decoder and analog monitor select register.
// Assumes: Host is serial master, 16-bit frames, reply in the next frame.
// Notes: Reply words are prepared in the core domain and crossed as stable words.
//
// Operation
// [R1] Read 00, bit7 0: status plus control bits.
// [R2] Read 00, bit7 1: status plus identity, I/O.
// [R3] Write 01: low byte to addressed register.
// [R4] Read 11: flags by sub-address bit 7.
// [R5] Flag reply leads with fixed status byte.
// [R6] Parity applies to write commands only.
// [R7] Parity counts bits 15-9 and 7-0.
// [R8] Host makes total ones count odd.
// [R9] Parity enabled by init bit 6.
// [R10] Bits 7-5 select monitored signal.
// [R11] Bit 4 enables internal sense resistor.
// [R12] Bit 3 gain/attenuation for I/O selections.
// [R13] Register clears on reset, regulator off, non-Normal.
// [R14] Access ignored and cleared when regulator off.
// [R15] Reserved commands change no state.
// [R16] Sixteen bit frames, MSB first, full duplex.
`timescale 1ns/100ps
module sbc_cmd #(
   parameter logic [7:0] IDENTITY_CODE = 8'h5A // Arbitrary value.
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic link_clock_i,
   input wire logic cs_b_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire logic [7:0] fixed_status_i,
   input wire logic [7:0] extended_status_i,
   input wire logic [7:0] control_readback_i,
   input wire logic [7:0] flags_low_i,
   input wire logic [7:0] flags_high_i,
   input wire logic [3:0] io_state_i,
   input wire logic normal_mode_i,
   input wire logic transceiver_supply_regulator_i,
   input wire logic parity_enable_i,
   output logic [4:0] flag_addr_o,
   output logic flag_sub_o,
   output logic write_o,
   output logic [4:0] write_addr_o,
   output logic [7:0] write_data_o,
   output logic flag_read_o,
   output logic parity_error_o,
   output logic [2:0] monitor_select_o,
   output logic internal_sense_resistor_enable_o,
   output logic attenuation_o
);
   import sbc_pkg::*;

   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   logic [FRAME_BITS-1:0] link_frame;
   logic link_tgl;
   logic [FRAME_BITS-1:0] reply_r;

   sbc_link u_link (
      .link_clock_i(link_clock_i),
      .rst_b_i(rst_b_i),
      .cs_b_i(cs_b_i),
      .mosi_i(mosi_i),
      .reply_i(reply_r),
      .miso_o(miso_o),
      .frame_o(link_frame),
      .done_tgl_o(link_tgl)
   );

   // ----------------------------------------------------------------
   // Crossings
   // ----------------------------------------------------------------
   logic tgl_s;
   logic tgl_d_r;
   logic reg_on_s;
   logic normal_s;
   logic par_en_s;

   sbc_sync #(.WIDTH(4)) u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .d_i({link_tgl, transceiver_supply_regulator_i, normal_mode_i, parity_enable_i}),
      .q_o({tgl_s, reg_on_s, normal_s, par_en_s})
   );

   // Frame word is stable for a whole frame after its toggle, so it is sampled on the event.
   logic frame_evt;
   sbc_frame_t frm;
   assign frame_evt = tgl_s ^ tgl_d_r;
   assign frm = link_frame;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic odd_ones(input logic [FRAME_BITS-1:0] w);
      odd_ones = ^w;
   endfunction : odd_ones

   wire logic is_write = frm.cmd == CMD_WRITE;
   wire logic is_rd_ctrl = frm.cmd == CMD_READ_CTRL;
   wire logic is_flags = frm.cmd == CMD_READ_FLAGS;
   wire logic is_mux = frm.addr == ADDR_ANALOG_MONITOR_SELECT;
   // Total frame ones must be odd: bits 15-9 and 7-0 plus bit 8.
   wire logic parity_ok = !par_en_s || odd_ones(link_frame); // [R7] [R8] [R9]
   wire logic write_ok = frame_evt && is_write && parity_ok; // [R6] [R15]
   wire logic parity_bad = frame_evt && is_write && !parity_ok; // [R6]
   wire logic mux_access = frame_evt && is_mux && (is_write || is_rd_ctrl);

   // ----------------------------------------------------------------
   // Analog monitor select register
   // ----------------------------------------------------------------
   logic [7:0] mux_r;
   logic [7:0] mux_nxt;

   always_comb begin
      mux_nxt = mux_r;
      if (!reg_on_s || !normal_s) begin
         mux_nxt = ANALOG_MONITOR_SELECT_RESET; // [R13] [R14]
      end else if (write_ok && mux_access) begin // [R14]
         mux_nxt = {frm.sub, frm.low} & ANALOG_MONITOR_SELECT_MASK; // [R3] [R13]
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         mux_r <= ANALOG_MONITOR_SELECT_RESET; // [R13]
         tgl_d_r <= 1'b0;
      end else begin
         mux_r <= mux_nxt;
         tgl_d_r <= tgl_s;
      end
   end

   assign monitor_select_o = mux_r[SEL_HI:SEL_LO]; // [R10]
   assign internal_sense_resistor_enable_o = mux_r[RES_EN_BIT]; // [R11]
   // Attenuation only matters for the two I/O selections.
   assign attenuation_o = mux_r[ATTEN_BIT] && (mux_r[SEL_HI:SEL_LO] == 3'h4 || mux_r[SEL_HI:SEL_LO] == 3'h5); // [R12]

   // ----------------------------------------------------------------
   // Reply for the next frame
   // ----------------------------------------------------------------
   logic [7:0] low_nxt;
   wire logic [7:0] ctrl_val = is_mux ? (reg_on_s ? mux_r : 8'h00) : control_readback_i;
   wire logic [7:0] flag_val = frm.sub ? flags_high_i : flags_low_i;

   always_comb begin
      case (frm.cmd)
         CMD_READ_CTRL: low_nxt = frm.sub ? {IDENTITY_CODE[7:4], io_state_i} : ctrl_val; // [R1] [R2]
         CMD_WRITE: low_nxt = extended_status_i; // [R3]
         CMD_READ_FLAGS: low_nxt = flag_val; // [R4] [R5]
         default: low_nxt = 8'h00; // [R15]
      endcase
   end

   logic wr_r;
   logic fr_r;
   logic pe_r;
   logic [4:0] wa_r;
   logic [7:0] wd_r;
   logic [4:0] fa_r;
   logic fs_r;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         reply_r <= SHIFT_RESET;
         wr_r <= 1'b0;
         fr_r <= 1'b0;
         pe_r <= 1'b0;
         wa_r <= 5'h00;
         wd_r <= 8'h00;
         fa_r <= 5'h00;
         fs_r <= 1'b0;
      end else begin
         wr_r <= write_ok && !is_mux; // [R3]
         fr_r <= frame_evt && is_flags; // [R4]
         pe_r <= parity_bad;
         if (frame_evt) begin
            reply_r <= {fixed_status_i, low_nxt}; // [R5] [R16]
            wa_r <= frm.addr;
            wd_r <= {frm.sub, frm.low};
            fa_r <= frm.addr;
            fs_r <= frm.sub;
         end
      end
   end

   assign write_o = wr_r;
   assign write_addr_o = wa_r;
   assign write_data_o = wd_r;
   assign flag_read_o = fr_r;
   assign flag_addr_o = fa_r;
   assign flag_sub_o = fs_r;
   assign parity_error_o = pe_r;
endmodule : sbc_cmd

/* testbench/sbc_cmd_asserts.sv */
// Purpose: Port assertions of the command decoder.
// Assumes: Core clock domain only.
// Notes: Bound to the decoder below.
`timescale 1ns/100ps
module sbc_cmd_asserts (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic normal_mode_i,
   input wire logic transceiver_supply_regulator_i,
   input wire logic write_o,
   input wire logic [4:0] write_addr_o,
   input wire logic flag_read_o,
   input wire logic parity_error_o,
   input wire logic [2:0] monitor_select_o,
   input wire logic internal_sense_resistor_enable_o,
   input wire logic attenuation_o
);
   wire [4:0] mon = {monitor_select_o, internal_sense_resistor_enable_o, attenuation_o};
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_off;
      !transceiver_supply_regulator_i [*4];
   endsequence
   sequence s_idle;
      (cs_b_i && transceiver_supply_regulator_i && normal_mode_i) [*8];
   endsequence
   chk_reg_off: assert property (s_off |-> mon == 5'h00) else $error("monitor set");
   chk_mode_off: assert property (!normal_mode_i [*4] |-> mon == 5'h00) else $error("monitor set");
   chk_rst_clear: assert property ($rose(rst_b_i) |-> mon == 5'h00 && !write_o) else $error("reset value");
   chk_mon_hold: assert property (s_idle |=> $stable(mon)) else $error("monitor moved");
   chk_wr_pulse: assert property (write_o |=> !write_o) else $error("write pulse");
   chk_wr_addr: assert property (write_o |-> write_addr_o != 5'h00 && !flag_read_o) else $error("write addr");
   chk_fl_pulse: assert property (flag_read_o |=> !flag_read_o) else $error("flag pulse");
   chk_par_err: assert property (parity_error_o |-> !write_o ##1 !parity_error_o) else $error("parity");
   chk_att_gate: assert property (attenuation_o |-> monitor_select_o == 3'h4 || monitor_select_o == 3'h5)
      else $error("attenuation");
endmodule : sbc_cmd_asserts
bind sbc_cmd sbc_cmd_asserts u_chk (.clock_i, .rst_b_i, .cs_b_i, .normal_mode_i, .transceiver_supply_regulator_i,
   .write_o, .write_addr_o, .flag_read_o, .parity_error_o, .monitor_select_o, .internal_sense_resistor_enable_o,
   .attenuation_o);

/* testbench/sbc_host_model.sv */
// Purpose: Host serial master model.
// Assumes: Link clock idles low and runs only inside frames.
// Notes: Data out is inverted once a frame ends.
`timescale 1ns/100ps
module sbc_host_model (
   output logic link_clock_o,
   output logic cs_b_o,
   output logic mosi_o,
   input wire logic miso_i,
   output logic [15:0] rx_o,
   output logic done_o
);
   initial begin
      link_clock_o = 1'b0;
      cs_b_o = 1'b1;
      mosi_o = 1'b0;
      done_o = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx);
      #1.3 cs_b_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = tx[i];
         #16 link_clock_o = 1'b1;
         rx_o[i] = miso_i;
         #16 link_clock_o = 1'b0;
      end
      #16 cs_b_o = 1'b1;
      mosi_o = ~tx[0];
      done_o = 1'b1;
      #1 done_o = 1'b0;
   endtask : xfer
endmodule : sbc_host_model

/* testbench/sbc_cmd_tb.sv */
// Purpose: Self-checking bench of the command decoder.
// Assumes: Host model drives the link.
// Notes: Each reply is checked one frame late.
`timescale 1ns/100ps
module sbc_cmd_tb;
   import sbc_pkg::*;
   localparam logic [7:0] IDC = 8'h3C; // Arbitrary value.
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reg_on = 1'b1, norm = 1'b1, pen = 1'b0, link_clk, cs_b, mosi, miso, wr, fr, pe, fs, ra, at, done, bad;
   logic [43:0] st = '0;
   logic [2:0] ms;
   logic [4:0] fa, wa, mon_exp = 5'h00;
   logic [7:0] wd;
   logic [1:0] cmd;
   logic [15:0] rx, tx, e, exp_q[$];
   logic [3:0] n_wr = 4'h0, n_fr = 4'h0, n_pe = 4'h0, w0, f0, p0;
   logic [12:0] last_wr;
   logic [5:0] last_fr;
   int miscompares = 0, n_compared = 0, frames = 0;
   sbc_cmd #(.IDENTITY_CODE(IDC)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .link_clock_i(link_clk),
      .cs_b_i(cs_b), .mosi_i(mosi), .miso_o(miso), .fixed_status_i(st[43:36]), .extended_status_i(st[35:28]),
      .control_readback_i(st[27:20]), .flags_low_i(st[19:12]), .flags_high_i(st[11:4]), .io_state_i(st[3:0]),
      .normal_mode_i(norm), .transceiver_supply_regulator_i(reg_on), .parity_enable_i(pen), .flag_addr_o(fa),
      .flag_sub_o(fs), .write_o(wr), .write_addr_o(wa), .write_data_o(wd), .flag_read_o(fr), .parity_error_o(pe),
      .monitor_select_o(ms), .internal_sense_resistor_enable_o(ra), .attenuation_o(at));
   sbc_host_model u_host (.link_clock_o(link_clk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso), .rx_o(rx),
      .done_o(done));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   initial begin
      forever #2 clock_i = ~clock_i;
   end
   initial begin
      repeat (100000) @(posedge clock_i);
      miscompares++;
      print_verdict();
   end
   always @(posedge clock_i) begin
      if (wr) begin
         n_wr <= n_wr + 4'h1;
         last_wr <= {wa, wd};
      end
      if (fr) begin
         n_fr <= n_fr + 4'h1;
         last_fr <= {fa, fs};
      end
      if (pe) n_pe <= n_pe + 4'h1;
   end
   always @(posedge done) begin
      frames++;
      if (frames > 1) check(rx, exp_q.pop_front());
   end
   initial begin
      void'($urandom(9738));
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge clock_i);
         st <= 44'({$urandom, $urandom});
         reg_on <= $urandom % 6 != 0;
         norm <= $urandom % 6 != 0;
         pen <= $urandom % 2 != 0;
         tx = 16'($urandom);
         bad = $urandom % 4 == 0;
         repeat (12) @(posedge clock_i);
         if (i < 4) tx[15:14] = 2'(i);
         cmd = tx[15:14];
         if (cmd == 2'h0 && !tx[7]) tx[9] = 1'b1;
         if (cmd == 2'h1 && i % 3 == 0) tx[13:9] = 5'h00;
         tx[8] = 1'b1;
         bad = bad & pen & cmd == 2'h1;
         if (cmd == 2'h1) tx[8] = pen & (bad ^ ~^{tx[15:9], tx[7:0]});
         else tx[6:0] = 7'h00;
         exp_q.push_back({st[43:36], cmd == 2'h1 ? st[35:28] : cmd == 2'h2 ? 8'h00 : cmd == 2'h3 ?
            (tx[7] ? st[11:4] : st[19:12]) : tx[7] ? {IDC[7:4], st[3:0]} : st[27:20]});
         if (cmd == 2'h1 && tx[13:9] == 5'h00 && !bad) mon_exp = {tx[7:4], tx[3] & (tx[7:5] == 3'h4 || tx[7:5] == 3'h5)};
         if (!reg_on || !norm) mon_exp = 5'h00;
         e = {7'h00, cmd == 2'h1 && tx[13:9] != 5'h00 && !bad, 3'h0, cmd == 2'h3, 3'h0, bad};
         {w0, f0, p0} = {n_wr, n_fr, n_pe};
         u_host.xfer(tx);
         repeat (20) @(posedge clock_i);
         check({11'h000, ms, ra, at}, {11'h000, mon_exp});
         check({4'h0, n_wr - w0, n_fr - f0, n_pe - p0}, e);
         if (e[8]) check({3'h0, last_wr}, {3'h0, tx[13:9], tx[7:0]});
         if (e[4]) check({10'h000, last_fr}, {10'h000, tx[13:9], tx[7]});
      end
      u_host.xfer(16'h8000);
      repeat (20) @(posedge clock_i);
      print_verdict();
   end
endmodule : sbc_cmd_tb
